// ===== pkg/tcw_pkg.sv
// Shared constants, mode decoding and helper functions for the timer waveform block.
package tcw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses on the APB bus.
   localparam logic [7:0] ADDR_CTRL_A = 8'h80;  // Output modes and low mode bits.
   localparam logic [7:0] ADDR_CTRL_B = 8'h84;  // High mode bits and clock select.
   localparam logic [7:0] ADDR_FORCE  = 8'h88;  // Force strobes, write only.
   localparam logic [7:0] ADDR_CMP_A  = 8'h8c;  // Channel A compare buffer.
   localparam logic [7:0] ADDR_CMP_B  = 8'h90;  // Channel B compare buffer.
   localparam logic [7:0] ADDR_TOP    = 8'h94;  // Fixed TOP value register.
   localparam logic [7:0] ADDR_COUNT  = 8'h98;  // Counter value, read only.
   localparam logic [7:0] ADDR_STATUS = 8'h9c;  // Sticky event flags.
   localparam logic [7:0] ADDR_MASK   = 8'ha0;  // Interrupt mask.

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values.
   localparam int         COM_A_LSB    = 6;      // Channel A output mode field.
   localparam int         COM_B_LSB    = 4;      // Channel B output mode field.
   localparam int         WGM_HI_LSB   = 3;      // High mode bits in control B.
   localparam logic [7:0] CTRL_A_WMASK = 8'hf3;  // Bits 3:2 do not exist.
   localparam logic [7:0] CTRL_A_RST   = 8'h00;  // Normal mode, both pins free.
   localparam int         ST_OVF       = 0;      // Overflow flag bit.
   localparam int         ST_MA        = 1;      // Channel A match flag bit.
   localparam int         ST_MB        = 2;      // Channel B match flag bit.

   ////////////////////////////////////////////////////////////////////////////
   // Counter limits.
   localparam logic [15:0] BOTTOM = 16'h0000;
   localparam logic [15:0] MAX    = 16'hffff;
   localparam logic [15:0] TOP_8  = 16'h00ff;
   localparam logic [15:0] TOP_9  = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;

   // Divider limits, in clock cycles minus one, for each prescale choice.
   localparam logic [9:0] DIV_1    = 10'h000;
   localparam logic [9:0] DIV_8    = 10'h007;
   localparam logic [9:0] DIV_64   = 10'h03f;
   localparam logic [9:0] DIV_256  = 10'h0ff;
   localparam logic [9:0] DIV_1024 = 10'h3ff;

   // Counting family chosen by the waveform mode.
   typedef enum logic [1:0] {K_NORMAL, K_CTC, K_FAST, K_DUAL} tcw_kind_e;

   // Sorts the sixteen waveform modes into their counting family.
   function automatic tcw_kind_e mode_kind(input logic [3:0] m);
      case (m)
         4'h4, 4'hc:                         mode_kind = K_CTC;
         4'h5, 4'h6, 4'h7, 4'he, 4'hf:       mode_kind = K_FAST;
         4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha,
         4'hb:                               mode_kind = K_DUAL;
         default:                            mode_kind = K_NORMAL;
      endcase
   endfunction

endpackage

// ===== tb/tcw_timer_test.sv
// Self-checking testbench for the timer waveform block.
`timescale 1ns/1ps
module tcw_timer_test;
   import tcw_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   logic        i_clk, i_sys_rst, i_psel, i_penable, i_pwrite;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic        o_pready, o_pslverr, err, wa, oa, wb, ob, o_irq;
   logic        dir_a, pin_a;
   int          mismatches, checked, cycles, n;
   // Ownership table: control A, control B, expected A and B ownership.
   logic [7:0]  own_a [5] = '{8'h50, 8'h51, 8'h53, 8'h51, 8'h53};
   logic [7:0]  own_b [5] = '{8'h00, 8'h08, 8'h18, 8'h00, 8'h10};
   logic [1:0]  own_e [5] = '{2'b11, 2'b00, 2'b10, 2'b00, 2'b10};
   tcw_timer i_tcw_timer (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .o_prdata(o_prdata), .o_chan_a_wave_out(wa), .o_chan_a_pin_override(oa),
      .o_chan_b_wave_out(wb), .o_chan_b_pin_override(ob), .o_irq(o_irq));
   // Pin driver: the waveform reaches the pin only once software makes it an output.
   assign pin_a = (dir_a && oa) ? wa : 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   // Compares a value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge i_clk);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite  <= w;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         k++;
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
      chk(k, 2, "wait states");
   endtask
   // Waits for a rising edge of wave A, then counts the cycles it stays high.
   task automatic high_len();
      int k;
      k = 0;
      n = 0;
      while (!(wa === 1'b0) && k < 2000) begin @(posedge i_clk); k++; end
      while (wa !== 1'b1 && k < 2000) begin @(posedge i_clk); k++; end
      while (wa === 1'b1 && n < 2000) begin @(posedge i_clk); n++; end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Reset values, bits 3:2 and an unmapped address.
   task automatic t_regs();
      chk({oa, ob, o_irq, wa}, 0, "reset pins");
      apb(0, ADDR_CTRL_A, 0);
      chk(rd, 0, "ctrl reset");
      apb(1, ADDR_CTRL_A, 32'hff);
      apb(0, ADDR_CTRL_A, 0);
      chk(rd, 32'hf3, "ctrl bits");
      apb(0, 8'hfc, 0);
      chk({err, rd}, {1'b1, 32'h0}, "unmapped");
      $display("test regs done");
   endtask
   // Normal mode set on match, flag, interrupt, clear.
   task automatic t_normal();
      dir_a <= 1'b1;
      apb(1, ADDR_CTRL_A, 32'hc0);
      apb(1, ADDR_CMP_A, 32'h3);
      apb(1, ADDR_MASK, 32'h2);
      apb(1, ADDR_CTRL_B, 32'h1);
      repeat (30) @(posedge i_clk);
      chk({wa, o_irq}, 2'b11, "set on match");
      chk(pin_a, 1, "pin a drive");
      apb(0, ADDR_STATUS, 0);
      chk(rd & 32'h2, 32'h2, "match flag");
      apb(1, ADDR_CTRL_B, 32'h0);
      apb(1, ADDR_STATUS, 32'h7);
      repeat (2) @(posedge i_clk);
      chk(o_irq, 0, "irq clear");
      $display("test normal done");
   endtask
   // Forced matches in normal mode, ignored in fast PWM.
   task automatic t_force();
      apb(1, ADDR_CTRL_A, 32'h80);
      apb(1, ADDR_FORCE, 32'h1);
      repeat (2) @(posedge i_clk);
      chk(wa, 0, "force clear");
      apb(1, ADDR_CTRL_A, 32'h40);
      apb(1, ADDR_FORCE, 32'h1);
      repeat (2) @(posedge i_clk);
      chk(wa, 1, "force toggle");
      apb(1, ADDR_CTRL_A, 32'h81);
      apb(1, ADDR_CTRL_B, 32'h08);
      apb(1, ADDR_FORCE, 32'h1);
      repeat (2) @(posedge i_clk);
      chk(wa, 1, "force in pwm");
      $display("test force done");
   endtask
   // Pin ownership across modes with toggle settings.
   task automatic t_owner();
      for (int i = 0; i < 5; i++) begin
         apb(1, ADDR_CTRL_B, {24'h0, own_b[i]});
         apb(1, ADDR_CTRL_A, {24'h0, own_a[i]});
         repeat (2) @(posedge i_clk);
         chk({oa, ob}, own_e[i], "ownership");
      end
      $display("test owner done");
   endtask
   // Fast PWM duty, and a compare value at TOP.
   task automatic t_fast();
      apb(1, ADDR_CTRL_B, 32'h08);
      apb(1, ADDR_CTRL_A, 32'h81);
      apb(1, ADDR_CMP_A, 32'h10);
      apb(1, ADDR_CTRL_B, 32'h09);
      high_len();
      high_len();
      chk(n, 17, "fast duty");
      apb(1, ADDR_CMP_A, {16'h0, TOP_8});
      repeat (600) @(posedge i_clk);
      high_len();
      chk(n, 2000, "match at top");
      $display("test fast done");
   endtask
   // Phase-correct duty and overflow at BOTTOM.
   task automatic t_dual();
      apb(1, ADDR_CTRL_B, 32'h0);
      apb(1, ADDR_CTRL_A, 32'h81);
      apb(1, ADDR_CMP_A, 32'h10);
      apb(1, ADDR_STATUS, 32'h7);
      apb(1, ADDR_CTRL_B, 32'h1);
      high_len();
      high_len();
      chk(n, 32, "dual duty");
      apb(0, ADDR_STATUS, 0);
      chk(rd & 32'h1, 32'h1, "overflow");
      apb(1, ADDR_CTRL_B, 32'h0);
      $display("test dual done");
   endtask
   // Clear-on-match counting: A toggles at TOP, B sets on its own match.
   task automatic t_ctc();
      apb(1, ADDR_CTRL_A, 32'h70);
      apb(1, ADDR_CTRL_B, 32'h08);
      apb(1, ADDR_CMP_A, {16'h0, TOP_8});
      apb(1, ADDR_CMP_B, 32'h2);
      apb(1, ADDR_CTRL_B, 32'h09);
      high_len();
      chk(n, 256, "ctc toggle");
      chk(wb, 1, "ctc set b");
      apb(1, ADDR_CTRL_B, 32'h0);
      $display("test ctc done");
   endtask
   // Frequency-correct mode 9: TOP comes from compare A, A toggles at TOP.
   task automatic t_pfc();
      apb(1, ADDR_CTRL_A, 32'h41);
      apb(1, ADDR_CMP_A, 32'h20);
      apb(1, ADDR_CTRL_B, 32'h11);
      high_len();
      high_len();
      chk(n, 64, "pfc toggle");
      apb(1, ADDR_CTRL_B, 32'h0);
      $display("test pfc done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Clock of 10 ns period.
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Cuts a hang short; the tests need well under this many cycles.
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         print_verdict();
      end
   end
   // Main sequence: reset for 10 cycles, then the tests.
   initial begin
      {i_sys_rst, i_psel, i_penable, i_pwrite} = 4'b1000;
      {i_paddr, i_pwdata, mismatches, checked, cycles, dir_a} = '0;
      repeat (10) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      t_regs();
      t_normal();
      t_force();
      t_owner();
      t_fast();
      t_dual();
      t_ctc();
      t_pfc();
      print_verdict();
   end
endmodule

// ===== verilog/tcw_tick_div.sv
// Prescaler that turns the I/O clock into a one-cycle timer tick enable.
`timescale 1ns/1ps
module tcw_tick_div
   import tcw_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // Prescale select
   input  wire logic [2:0] i_clk_sel,
   // Tick enable
   output logic            o_tick
);

   // All state of the divider.
   typedef struct packed {
      logic [9:0] cnt;   // Cycles since the last tick.
      logic       tick;  // Registered tick enable.
   } tcw_div_s;

   tcw_div_s   r_reg;    // Present state.
   tcw_div_s   r_next;   // Next state.
   logic [9:0] lim;      // Divider limit for the present select.
   logic       run;      // Select names a running rate.

   ////////////////////////////////////////////////////////////////////////////
   // Select decode; the external clock choices have no pin here and stop.
   always_comb begin
      run = 1'b1;
      case (i_clk_sel)
         3'h1:    lim = DIV_1;
         3'h2:    lim = DIV_8;
         3'h3:    lim = DIV_64;
         3'h4:    lim = DIV_256;
         3'h5:    lim = DIV_1024;
         default: begin
            lim = DIV_1;
            run = 1'b0;
         end
      endcase
   end

   // The tick is an enable on the single clock, never a clock of its own.
   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'b0;
      if (!run) begin
         r_next.cnt = 10'h000;
      end else if (r_reg.cnt >= lim) begin
         r_next.cnt = 10'h000;
         r_next.tick = 1'b1;
      end else begin
         r_next.cnt = r_reg.cnt + 10'h001;
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_tick = r_reg.tick;

endmodule

// ===== verilog/tcw_timer.sv
// Sixteen-bit timer with two compare channels, waveform modes and an APB register file.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module tcw_timer
   import tcw_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic [31:0]      o_prdata,
   // Waveform pins
   output logic             o_chan_a_wave_out,
   output logic             o_chan_a_pin_override,
   output logic             o_chan_b_wave_out,
   output logic             o_chan_b_pin_override,
   // Interrupt
   output logic             o_irq
);

   // All state of the timer.
   typedef struct packed {
      logic [7:0]  ctrl_a;     // Output modes and low mode bits.
      logic [1:0]  wgm_hi;     // High mode bits.
      logic [2:0]  clk_sel;    // Prescale select.
      logic [15:0] buf_a;      // Compare buffer A.
      logic [15:0] buf_b;      // Compare buffer B.
      logic [15:0] cmp_a;      // Active compare A.
      logic [15:0] cmp_b;      // Active compare B.
      logic [15:0] top_val;    // Fixed TOP register.
      logic [15:0] cnt;        // Counter.
      logic        up;         // Dual-slope direction.
      logic [2:0]  status;     // Sticky flags.
      logic [2:0]  mask;       // Interrupt mask.
      logic        wave_a;     // Channel A output level.
      logic        wave_b;     // Channel B output level.
      logic        ovr_a;      // Channel A owns its pin.
      logic        ovr_b;      // Channel B owns its pin.
      logic        irq;        // Interrupt level.
      logic        pready;     // Bus answer.
      logic        pslverr;    // Bus error.
      logic [31:0] prdata;     // Bus read data.
   } tcw_state_s;

   tcw_state_s  r_reg;         // Present state.
   tcw_state_s  r_next;        // Next state.
   logic        tick;          // Timer tick enable.
   logic [3:0]  mode;          // Waveform mode.
   tcw_kind_e   kind;          // Counting family.
   logic [1:0]  com_a;         // Channel A output mode.
   logic [1:0]  com_b;         // Channel B output mode.
   logic [15:0] top;           // Present TOP.
   logic        at_top;        // Counter sits at TOP.
   logic        at_bot;        // Counter sits at BOTTOM.
   logic        wr;            // A write completes now.
   logic        wrap;          // Fast PWM returns to BOTTOM.
   logic        ma;            // Channel A compare match.
   logic        mb;            // Channel B compare match.
   logic        upd;           // Buffered compare load event.
   logic        ovf;           // Overflow event.
   logic        fa;            // Channel A force strobe.
   logic        fb;            // Channel B force strobe.

   ////////////////////////////////////////////////////////////////////////////
   // Next output level of one channel for the present mode and events.
   function automatic logic wave_nx(input tcw_kind_e k, input logic [3:0] m,
                                    input logic [1:0] com, input logic is_a,
                                    input logic match, input logic cmp_top,
                                    input logic up, input logic wrp,
                                    input logic frc, input logic cur);
      logic v;
      v = cur;
      case (k)
         K_FAST: begin
            if (com == 2'b01) begin
               if (is_a && m >= 4'he && match) v = ~cur;
            end else if (com[1]) begin
               if (wrp) v = ~com[0];
               else if (match && !cmp_top) v = com[0];
            end
         end
         K_DUAL: begin
            if (com == 2'b01) begin
               if (is_a && (m == 4'h9 || m == 4'hb) && match) v = ~cur;
            end else if (com[1] && match) begin
               v = up ? com[0] : ~com[0];
            end
         end
         default: begin
            // Forced matches count only here, outside the PWM families.
            if (match || frc) begin
               case (com)
                  2'b01:   v = ~cur;
                  2'b10:   v = 1'b0;
                  2'b11:   v = 1'b1;
                  default: v = cur;
               endcase
            end
         end
      endcase
      wave_nx = v;
   endfunction

   // Whether a channel owns its pin; toggle settings stay off where unsupported.
   function automatic logic owns_pin(input tcw_kind_e k, input logic [3:0] m,
                                     input logic [1:0] com, input logic is_a);
      logic ok;
      ok = (com != 2'b00);
      if (com == 2'b01 && k == K_FAST) ok = is_a && m >= 4'he;
      if (com == 2'b01 && k == K_DUAL) ok = is_a && (m == 4'h9 || m == 4'hb);
      owns_pin = ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler gives the tick enable on the I/O clock.
   tcw_tick_div i_tcw_tick_div (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_clk_sel (r_reg.clk_sel),
      .o_tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode and events, taken from the present state and the bus inputs.
   assign mode   = {r_reg.wgm_hi, r_reg.ctrl_a[1:0]};
   assign kind   = mode_kind(mode);
   assign com_a  = r_reg.ctrl_a[COM_A_LSB +: 2];
   assign com_b  = r_reg.ctrl_a[COM_B_LSB +: 2];
   assign at_top = (r_reg.cnt == top);
   assign at_bot = (r_reg.cnt == BOTTOM);
   assign wr     = i_psel && i_penable && r_reg.pready && i_pwrite;
   assign wrap   = tick && kind == K_FAST && at_top;
   assign ma     = tick && r_reg.cnt == r_reg.cmp_a;
   assign mb     = tick && r_reg.cnt == r_reg.cmp_b;
   assign fa     = wr && i_paddr == ADDR_FORCE && i_pwdata[0];
   assign fb     = wr && i_paddr == ADDR_FORCE && i_pwdata[1];

   // TOP source per mode; the reserved mode runs as a plain counter.
   always_comb begin
      case (mode)
         4'h1, 4'h5:                top = TOP_8;
         4'h2, 4'h6:                top = TOP_9;
         4'h3, 4'h7:                top = TOP_10;
         4'h4, 4'h9, 4'hb, 4'hf:    top = r_reg.cmp_a;
         4'h8, 4'ha, 4'hc, 4'he:    top = r_reg.top_val;
         default:                   top = MAX;
      endcase
   end

   // Load and overflow moments; frequency-correct modes use BOTTOM for both.
   always_comb begin
      case (kind)
         K_FAST: begin
            upd = wrap;
            ovf = wrap;
         end
         K_DUAL: begin
            upd = tick && (mode[3:1] == 3'h4 ? at_bot : at_top);
            ovf = tick && at_bot;
         end
         default: begin
            upd = 1'b0;
            ovf = tick && r_reg.cnt == MAX;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state: counter, outputs, flags and the bus slave.
   always_comb begin
      r_next = r_reg;
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;

      // Counting sequence, advanced only on a tick.
      if (tick) begin
         case (kind)
            K_NORMAL: r_next.cnt = r_reg.cnt + 16'h0001;
            K_DUAL: begin
               if (r_reg.up ? at_top : !at_bot) begin
                  r_next.up = r_reg.up ? 1'b0 : r_reg.up;
                  r_next.cnt = r_reg.cnt - 16'h0001;
               end else begin
                  r_next.up = 1'b1;
                  r_next.cnt = r_reg.cnt + 16'h0001;
               end
            end
            default: r_next.cnt = at_top ? BOTTOM : r_reg.cnt + 16'h0001;
         endcase
      end

      // Compare loads: direct in unbuffered modes, else at the load event.
      if (kind == K_NORMAL || kind == K_CTC || upd) begin
         r_next.cmp_a = r_reg.buf_a;
         r_next.cmp_b = r_reg.buf_b;
      end

      // Output levels and pin ownership.
      r_next.wave_a = wave_nx(kind, mode, com_a, 1'b1, ma, r_reg.cmp_a == top,
                              r_reg.up, wrap, fa, r_reg.wave_a);
      r_next.wave_b = wave_nx(kind, mode, com_b, 1'b0, mb, r_reg.cmp_b == top,
                              r_reg.up, wrap, fb, r_reg.wave_b);
      r_next.ovr_a = owns_pin(kind, mode, com_a, 1'b1);
      r_next.ovr_b = owns_pin(kind, mode, com_b, 1'b0);

      // Sticky flags: a new event wins over a write-one clear.
      r_next.status = r_reg.status & ~((wr && i_paddr == ADDR_STATUS) ?
                                       i_pwdata[2:0] : 3'h0);
      if (ovf) r_next.status[ST_OVF] = 1'b1;
      if (ma) r_next.status[ST_MA] = 1'b1;
      if (mb) r_next.status[ST_MB] = 1'b1;

      // Register writes land at the completing access edge.
      if (wr) begin
         case (i_paddr)
            ADDR_CTRL_A: r_next.ctrl_a = i_pwdata[7:0] & CTRL_A_WMASK;
            ADDR_CTRL_B: begin
               r_next.wgm_hi = i_pwdata[WGM_HI_LSB +: 2];
               r_next.clk_sel = i_pwdata[2:0];
            end
            ADDR_CMP_A:  r_next.buf_a = i_pwdata[15:0];
            ADDR_CMP_B:  r_next.buf_b = i_pwdata[15:0];
            ADDR_TOP:    r_next.top_val = i_pwdata[15:0];
            ADDR_MASK:   r_next.mask = i_pwdata[2:0];
            default:     r_next.mask = r_reg.mask;
         endcase
      end
      r_next.irq = |(r_next.status & r_next.mask);

      // One wait state: data and answer are prepared in the first access cycle.
      if (i_psel && i_penable && !r_reg.pready) begin
         r_next.pready = 1'b1;
         r_next.prdata = 32'h0000_0000;
         case (i_paddr)
            ADDR_CTRL_A: r_next.prdata[7:0] = r_reg.ctrl_a;
            ADDR_CTRL_B: r_next.prdata[4:0] = {r_reg.wgm_hi, r_reg.clk_sel};
            ADDR_FORCE:  r_next.prdata = 32'h0000_0000;
            ADDR_CMP_A:  r_next.prdata[15:0] = r_reg.buf_a;
            ADDR_CMP_B:  r_next.prdata[15:0] = r_reg.buf_b;
            ADDR_TOP:    r_next.prdata[15:0] = r_reg.top_val;
            ADDR_COUNT:  r_next.prdata[15:0] = r_reg.cnt;
            ADDR_STATUS: r_next.prdata[2:0] = r_reg.status;
            ADDR_MASK:   r_next.prdata[2:0] = r_reg.mask;
            default:     r_next.pslverr = 1'b1;
         endcase
      end
   end

   // State register; reset puts every control bit at zero.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         r_reg <= '0;
         r_reg.up <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_pready              = r_reg.pready;
   assign o_pslverr             = r_reg.pslverr;
   assign o_prdata              = r_reg.prdata;
   assign o_chan_a_wave_out     = r_reg.wave_a;
   assign o_chan_a_pin_override = r_reg.ovr_a;
   assign o_chan_b_wave_out     = r_reg.wave_b;
   assign o_chan_b_pin_override = r_reg.ovr_b;
   assign o_irq                 = r_reg.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the timer behaviour.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_dual_top;
      tick && kind == K_DUAL && r_reg.up && at_top && top != BOTTOM;
   endsequence
   sequence s_turned_down;
      !r_reg.up && r_reg.cnt == $past(r_reg.cnt) - 16'h0001;
   endsequence

   chk_dual_turn: assert property (s_dual_top |=> s_turned_down)
      else $error("dual slope did not turn at TOP");
   chk_tick_gate: assert property (!tick && !$past(i_sys_rst) |=> $stable(r_reg.cnt))
      else $error("counter moved without a tick");
   chk_reset_zero: assert property ($past(i_sys_rst) |-> r_reg.ctrl_a == 8'h00
      && !o_chan_a_pin_override && !o_chan_b_pin_override)
      else $error("control not zero after reset");
   chk_pfc_load: assert property (tick && kind == K_DUAL && mode[3:1] == 3'h4
      && at_bot |=> r_reg.cmp_a == $past(r_reg.buf_a))
      else $error("frequency-correct load missed at BOTTOM");
   chk_ovf_bottom: assert property (tick && kind == K_DUAL && at_bot
      |=> r_reg.status[ST_OVF] && (o_irq || !r_reg.mask[ST_OVF]))
      else $error("overflow not raised at BOTTOM");
   chk_fast_hold: assert property (kind == K_FAST && !wrap
      && $stable(r_reg.ctrl_a) |=> $stable(r_reg.cmp_a))
      else $error("buffered compare loaded early");
   chk_pin_take: assert property (kind == K_NORMAL && com_a != 2'b00
      |=> o_chan_a_pin_override)
      else $error("channel A did not take its pin");
   chk_ctc_high: assert property (kind == K_CTC && com_a == 2'b11 && ma
      |=> o_chan_a_wave_out)
      else $error("set on match failed");
   chk_fast_bottom: assert property (kind == K_FAST && com_a == 2'b10 && wrap
      |=> o_chan_a_wave_out)
      else $error("fast output not set at BOTTOM");
   chk_fast_no_tgl: assert property (kind == K_FAST && com_b == 2'b01
      |=> !o_chan_b_pin_override)
      else $error("channel B toggle not disconnected");
   chk_dual_down: assert property (kind == K_DUAL && com_a == 2'b10 && ma
      && !r_reg.up |=> o_chan_a_wave_out)
      else $error("down-count match did not set");
   chk_force_pwm: assert property (kind == K_DUAL && fa && !ma
      |=> $stable(o_chan_a_wave_out))
      else $error("force acted in a PWM mode");
   chk_mode0_wrap: assert property (mode == 4'h0 && tick && r_reg.cnt == MAX
      |=> r_reg.cnt == BOTTOM && r_reg.status[ST_OVF])
      else $error("normal mode wrap or overflow wrong");
   chk_ctrl_rsvd: assert property (o_pready && i_paddr == ADDR_CTRL_A && !i_pwrite
      |-> o_prdata[3:2] == 2'b00)
      else $error("reserved control bits read nonzero");

endmodule
